// file: dv/ecdm_ctrl_tb.sv
// Self-checking bench for the external memory controller
`timescale 1ns/1ps
`default_nettype none
module ecdm_ctrl_tb;
  logic clk, rst_n, config_strap_pin, usb_host_sel, code_width16, data_width16, code_type_x16;
  logic exec_in_ram, serial_boot_en, serial_boot_done, host_load_done, nv_image_present;
  logic acc_req, acc_write, acc_data_space, acc_byte, acc_rom_hit, seen_c, seen_d;
  logic [7:0] overlay_sect_en;
  logic [21:0] acc_addr;
  logic [15:0] acc_wdata, rd;
  logic [20:0] last_a;
  wire acc_ready, code_cs_n, data_cs_n, byte_pin_multi, low_write_strobe, mem_output_enable;
  wire lower_byte_enable, mem_dout_en, instr_clk_en, slow_clock_active, run_enable;
  wire ser_clk, ser_tick, data_type_x16;
  wire [15:0] acc_rdata, mem_dout, mem_din, cdo, ddo;
  wire [20:0] mem_addr;
  integer failures = 0;
  integer check_count = 0;
  ecdm_ctrl u_ecdm_ctrl (
    .clk(clk), .rst_n(rst_n), .config_strap_pin(config_strap_pin), .usb_host_sel(usb_host_sel),
    .code_width16(code_width16), .data_width16(data_width16), .code_type_x16(code_type_x16),
    .overlay_sect_en(overlay_sect_en), .exec_in_ram(exec_in_ram), .serial_boot_en(serial_boot_en),
    .serial_boot_done(serial_boot_done), .host_load_done(host_load_done), .nv_image_present(nv_image_present),
    .acc_req(acc_req), .acc_write(acc_write), .acc_data_space(acc_data_space), .acc_byte(acc_byte),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rom_hit(acc_rom_hit), .acc_ready(acc_ready),
    .acc_rdata(acc_rdata), .code_cs_n(code_cs_n), .data_cs_n(data_cs_n), .mem_addr(mem_addr),
    .byte_pin_multi(byte_pin_multi), .low_write_strobe(low_write_strobe), .mem_output_enable(mem_output_enable),
    .lower_byte_enable(lower_byte_enable), .mem_dout(mem_dout), .mem_dout_en(mem_dout_en), .mem_din(mem_din),
    .instr_clk_en(instr_clk_en), .slow_clock_active(slow_clock_active), .run_enable(run_enable),
    .ser_clk(ser_clk), .ser_tick(ser_tick), .data_type_x16(data_type_x16));
  ecdm_mem_model u_code_mem (.clk(clk), .cs_n(code_cs_n), .w16(code_width16), .x16(code_type_x16),
    .pin_m(byte_pin_multi), .we_lo(low_write_strobe), .oe_n(mem_output_enable),
    .lbe_n(lower_byte_enable), .addr(mem_addr), .din(mem_dout), .dout(cdo));
  ecdm_mem_model u_data_mem (.clk(clk), .cs_n(data_cs_n), .w16(data_width16), .x16(data_type_x16),
    .pin_m(byte_pin_multi), .we_lo(low_write_strobe), .oe_n(mem_output_enable),
    .lbe_n(lower_byte_enable), .addr(mem_addr), .din(mem_dout), .dout(ddo));
  assign mem_din = !code_cs_n ? cdo : ddo;
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!code_cs_n)
      seen_c <= 1;
    if (!data_cs_n) begin
      seen_d <= 1;
      last_a <= mem_addr;
    end
  end
  task chk(input [20:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task acc(input w, d, b, input [21:0] a, input [15:0] v);
    integer n;
    @(posedge clk);
    #1;
    n = 0;
    seen_c = 0;
    seen_d = 0;
    {acc_write, acc_data_space, acc_byte, acc_addr, acc_wdata} = {w, d, b, a, v};
    acc_req = 1;
    do begin
      @(negedge clk);
      n++;
    end while (acc_ready !== 1'b1 && n < 300);
    @(posedge clk);
    #1 acc_req = 0;
    rd = acc_rdata;
    chk(n < 300, 1, "no ready");
  endtask
  task clk_slots(input integer exp);
    integer k;
    k = 0;
    repeat (8) begin
      @(negedge clk);
      k += instr_clk_en;
    end
    chk(k, exp, "instruction clock slots");
  endtask
  // One high phase of the serial clock, counted in system clocks
  task ser_half(input integer exp);
    integer k, t;
    k = 0;
    t = 0;
    @(posedge ser_clk);
    while (ser_clk === 1'b1 && k < 600) begin
      @(posedge clk);
      #1;
      k++;
      t += ser_tick;
    end
    chk(k, exp, "serial clock half period");
    chk(t, 1, "serial tick count");
  endtask
  task t_boot;
    chk({code_cs_n, data_cs_n, mem_output_enable, low_write_strobe}, 4'hf, "idle strobes");
    chk(slow_clock_active, 1, "slow after reset");
    clk_slots(2);
    repeat (20) @(posedge clk);
    chk(run_enable, 0, "run before boot done");
    ser_half(250);
    @(posedge clk);
    #1 serial_boot_done = 1;
    repeat (10) @(posedge clk);
    chk(run_enable, 1, "run after boot");
    chk(ser_clk, 0, "serial clock parked");
    acc(1, 0, 1, 22'h00_0011, 16'h00c3);
    acc(1, 0, 1, 22'h00_0010, 16'h003c);
    acc(0, 0, 1, 22'h00_0011, 0);
    chk(rd[7:0], 8'hc3, "code byte odd");
    chk({seen_c, seen_d}, 2'b10, "code select only");
    $display("test boot done");
  endtask
  task t_fast;
    @(posedge clk);
    #1 exec_in_ram = 1;
    @(posedge clk);
    #1 exec_in_ram = 0;
    repeat (4) @(posedge clk);
    chk(slow_clock_active, 0, "slow ended");
    clk_slots(8);
    acc(0, 0, 1, 22'h00_0010, 0);
    chk(rd[7:0], 8'h3c, "code byte even");
    $display("test fast done");
  endtask
  task t_wide;
    // Code space built from two x8 parts, data space from one x16 part
    code_width16 = 1;
    code_type_x16 = 0;
    acc(1, 0, 0, 22'h00_0020, 16'h1234);
    acc(1, 0, 1, 22'h00_0021, 16'h0077);
    acc(0, 0, 0, 22'h00_0020, 0);
    chk(rd, 16'h7734, "x8 pair word");
    acc(1, 1, 0, 22'h00_0040, 16'hbeef);
    acc(1, 1, 1, 22'h00_0040, 16'h0011);
    acc(0, 1, 0, 22'h00_0040, 0);
    chk(rd, 16'hbe11, "x16 word");
    chk({seen_c, seen_d}, 2'b01, "data select only");
    data_width16 = 0;
    acc(1, 1, 1, 22'h00_0051, 16'h005a);
    acc(0, 1, 1, 22'h00_0051, 0);
    chk(rd[7:0], 8'h5a, "data byte");
    $display("test wide done");
  endtask
  task t_map;
    overlay_sect_en = 8'h80;
    acc(0, 0, 0, 22'h01_c000, 0);
    chk({seen_c, seen_d}, 2'b01, "overlay select");
    chk(last_a, 21'h07_e000, "overlay address");
    acc_rom_hit = 1;
    acc(0, 0, 0, 22'h01_c000, 0);
    chk({seen_c, seen_d}, 2'b10, "rom region not overlaid");
    acc_rom_hit = 0;
    acc(0, 1, 1, 22'h3f_fff0, 0);
    chk(last_a, 21'h07_fff8, "usb address limit");
    usb_host_sel = 0;
    repeat (2) @(posedge clk);
    acc(0, 1, 1, 22'h3f_fff0, 0);
    chk(last_a, 21'h1f_fff8, "full address space");
    acc(0, 0, 0, 22'h01_c000, 0);
    chk(last_a, 21'h1f_e000, "overlay at top of 4MB");
    $display("test map done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_n, usb_host_sel, code_width16, data_width16, code_type_x16, exec_in_ram} = 6'b010110;
    {serial_boot_en, serial_boot_done, host_load_done, nv_image_present, acc_rom_hit} = 5'b10010;
    {acc_req, acc_write, acc_data_space, acc_byte, seen_c, seen_d} = 0;
    {overlay_sect_en, acc_addr, acc_wdata, last_a} = 0;
    config_strap_pin = 1;
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    chk(data_type_x16, 1, "strap sampled");
    t_boot;
    t_fast;
    t_wide;
    t_map;
    print_verdict;
  end
  initial begin
    #200000;
    failures++;
    print_verdict;
  end
endmodule
bind ecdm_ctrl ecdm_monitor #(.ADDR_W(ADDR_W)) u_ecdm_monitor (
  .clk(clk), .rst_n(rst_n), .code_cs_n(code_cs_n), .data_cs_n(data_cs_n), .acc_ready(acc_ready),
  .acc_byte(acc_byte), .byte_pin_multi(byte_pin_multi), .low_write_strobe(low_write_strobe),
  .mem_output_enable(mem_output_enable), .lower_byte_enable(lower_byte_enable), .mem_dout_en(mem_dout_en),
  .code_width16(code_width16), .data_width16(data_width16), .data_type_x16(data_type_x16),
  .instr_clk_en(instr_clk_en), .slow_clock_active(slow_clock_active), .run_enable(run_enable),
  .serial_boot_done(serial_boot_done), .nv_image_present(nv_image_present), .host_load_done(host_load_done),
  .acc_addr(acc_addr));
`default_nettype wire

// file: dv/ecdm_mem_model.sv
// Behavioural x8 or x16 static memory for one space
`timescale 1ns/1ps
`default_nettype none
module ecdm_mem_model (
  input wire clk, cs_n, w16, x16, pin_m, we_lo, oe_n, lbe_n,
  input wire [20:0] addr,
  input wire [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mem [0:65535];
  logic [15:0] idle_pat = 16'h5a5a;
  wire [15:0] ix = addr[15:0];
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
    if (!cs_n && !w16 && !we_lo) begin
      if (pin_m)
        mem[ix][15:8] <= din[7:0];
      else
        mem[ix][7:0] <= din[7:0];
    end
    if (!cs_n && w16 && (!x16 || !we_lo)) begin
      if (x16 ? !lbe_n : !we_lo)
        mem[ix][7:0] <= din[7:0];
      if (!pin_m)
        mem[ix][15:8] <= din[15:8];
    end
  end
  // Released lanes toggle so stale data can never pass as a read
  always @* begin
    dout = idle_pat;
    if (!cs_n && !oe_n)
      dout = w16 ? mem[ix] : {idle_pat[15:8], pin_m ? mem[ix][15:8] : mem[ix][7:0]};
  end
endmodule
`default_nettype wire

// file: dv/ecdm_monitor.sv
// Checker for the external memory pin protocol
`timescale 1ns/1ps
`default_nettype none
module ecdm_monitor #(parameter integer ADDR_W = 22) (
  input wire clk, rst_n, code_cs_n, data_cs_n, acc_ready, acc_byte,
  input wire byte_pin_multi, low_write_strobe, mem_output_enable, lower_byte_enable,
  input wire mem_dout_en, code_width16, data_width16, data_type_x16, instr_clk_en,
  input wire slow_clock_active, run_enable, serial_boot_done, nv_image_present, host_load_done,
  input wire [ADDR_W-1:0] acc_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire sel8 = (!code_cs_n && !code_width16) || (!data_cs_n && !data_width16);
  one_cs_a: assert property (code_cs_n || data_cs_n) else $error("both selects low");
  ready_lat_a: assert property ($fell(code_cs_n) || $fell(data_cs_n) |-> ##2 acc_ready)
    else $error("ready missing");
  cs_hold_a: assert property ($fell(data_cs_n) |-> !data_cs_n [*2]) else $error("select short");
  oe_read_a: assert property (!mem_output_enable |-> !mem_dout_en && !(code_cs_n && data_cs_n))
    else $error("read strobe misuse");
  oe_pulse_a: assert property ($fell(mem_output_enable) |=> mem_output_enable) else $error("read strobe long");
  wr_only_a: assert property (!low_write_strobe |-> mem_dout_en && mem_output_enable)
    else $error("write strobe misuse");
  byte_addr_a: assert property (sel8 |-> byte_pin_multi == acc_addr[0]) else $error("byte pin not lsb");
  ube_x16_a: assert property (!data_cs_n && data_width16 && data_type_x16 && !acc_byte &&
    !mem_output_enable |-> !byte_pin_multi && !lower_byte_enable) else $error("byte enables off");
  fast_clk_a: assert property (!slow_clock_active |=> instr_clk_en) else $error("clock gated");
  run_gate_a: assert property ($rose(run_enable) |-> $past(serial_boot_done) &&
    ($past(nv_image_present) || $past(host_load_done))) else $error("early run");
  cover property (!data_cs_n && !low_write_strobe);
  cover property (!code_cs_n && !mem_output_enable);
  cover property ($fell(slow_clock_active));
endmodule
`default_nettype wire

// file: rtl/ecdm_ctrl.v
// External code and data memory controller: strobes, overlay, boot clocking
//
// Summary of operation
// RULE1 - Separate chip selects for code space and data space.
// RULE2 - Address space at most 4MB, 1MB when USB is the host interface.
// RULE3 - Code space outside internal ROM is reachable as data through overlay.
// RULE4 - Data RAM maps code in 16KB sections from the top of memory downward.
// RULE5 - Slow instruction clock after reset until execution moves to RAM.
// RULE6 - No memory speed sensing; slow timing only from post-reset slow clock.
// RULE7 - Memory type selected by sampling the strap pin at reset.
// RULE8 - 8-bit space: byte pin is address LSB, low strobe writes, output enable reads.
// RULE9 - 16-bit from two x8: byte pin high write enable, low strobe low write enable.
// RULE10 - 16-bit from one x16: byte pin upper enable, lower byte enable pin lower.
// RULE11 - Pin roles switch per access by space; widths independent per space.
// RULE12 - Each space is built from one memory type, x8 or x16.
// RULE13 - Data SRAM should be 16 bits wide for full rate operation.
// RULE14 - System provides at least 128KB of external SRAM.
// RULE15 - Without a code image, host loads firmware first; device waits.
// RULE16 - After reset boot ROM copies card data from serial memory to RAM.
// RULE17 - Serial boot memory port clock runs at 400kHz.
// RULE18 - Memory strobes active low; at most one chip select per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ecdm_defs.vh"

module ecdm_ctrl #(
  parameter integer ADDR_W = `ECDM_ADDR_W,
  parameter integer SYS_HZ = `ECDM_SYS_HZ,
  parameter integer SER_HZ = `ECDM_SER_HZ
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // Straps and system inputs (asynchronous pins)
  input  wire              config_strap_pin,
  input  wire              usb_host_sel,
  // Firmware configuration
  input  wire              code_width16,
  input  wire              data_width16,
  input  wire              code_type_x16,
  input  wire [7:0]        overlay_sect_en,
  input  wire              exec_in_ram,
  input  wire              serial_boot_en,
  input  wire              serial_boot_done,
  input  wire              host_load_done,
  input  wire              nv_image_present,
  // Processor access request
  input  wire              acc_req,
  input  wire              acc_write,
  input  wire              acc_data_space,
  input  wire              acc_byte,
  input  wire [ADDR_W-1:0] acc_addr,
  input  wire [15:0]       acc_wdata,
  input  wire              acc_rom_hit,
  output wire              acc_ready,
  output reg  [15:0]       acc_rdata,
  // Memory pins
  output reg               code_cs_n,
  output reg               data_cs_n,
  output reg  [ADDR_W-2:0] mem_addr,
  output reg               byte_pin_multi,
  output reg               low_write_strobe,
  output reg               mem_output_enable,
  output reg               lower_byte_enable,
  output reg  [15:0]       mem_dout,
  output reg               mem_dout_en,
  input  wire [15:0]       mem_din,
  // Clocking and boot status
  output reg               instr_clk_en,
  output wire              slow_clock_active,
  output reg               run_enable,
  output wire              ser_clk,
  output wire              ser_tick,
  output reg               data_type_x16
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ADDR = 4'b0010;
  localparam [3:0] ST_STRB = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0]        state_reg;
  reg [1:0]        strap_sync_reg;
  reg [1:0]        usb_sync_reg;
  reg              strap_taken_reg;
  reg [1:0]        strap_wait_reg;
  reg              slow_reg;
  reg [7:0]        div_reg;
  reg              sel_data_reg;
  reg              w16_reg;
  reg              x16_reg;
  reg [ADDR_W-1:0] phys_addr;
  reg [ADDR_W-1:0] lim_addr;
  reg              is_data;
  reg              w16;
  reg              x16;
  wire             usb_mode = usb_sync_reg[1];
  wire [`ECDM_SECT_W-1:0] sect = acc_addr[`ECDM_SECT_MSB:`ECDM_SECT_LSB];

  // Overlay sections are counted from the top of physical memory downward
  function [ADDR_W-1:0] overlay_addr;
    input [ADDR_W-1:0]       a;
    input                    usb;
    reg   [ADDR_W-1:0]       top;
    begin
      top = usb ? ({ADDR_W{1'b0}} | {`ECDM_USB_ADDR_W{1'b1}}) : {ADDR_W{1'b1}};
      overlay_addr = top - ({ADDR_W{1'b0}} | {`ECDM_CODE_ADDR_W{1'b1}})
                     + ({ADDR_W{1'b0}} | a[`ECDM_CODE_ADDR_W-1:0]); // RULE4
    end
  endfunction

  assign slow_clock_active = slow_reg;
  assign acc_ready = (state_reg == ST_DONE);

  // Two-flop synchronisers for pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync_reg <= 2'b00;
      usb_sync_reg   <= 2'b00;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], config_strap_pin};
      usb_sync_reg   <= {usb_sync_reg[0], usb_host_sel};
    end
  end

  // Strap caught once after release, held until next reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_reg  <= 2'b00;
      strap_taken_reg <= 1'b0;
      data_type_x16   <= `ECDM_TYPE_X8;
    end else begin
      strap_wait_reg <= {strap_wait_reg[0], 1'b1};
      // Wait until the synchroniser holds a real pin sample, not its reset value
      if (strap_wait_reg[1] && !strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        data_type_x16   <= strap_sync_reg[1]; // RULE7
      end
    end
  end

  // Slow clock from reset until firmware runs from RAM; no speed sensing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_reg     <= 1'b1;
      div_reg      <= `ECDM_ZERO8;
      instr_clk_en <= 1'b0;
    end else begin
      if (exec_in_ram)
        slow_reg <= 1'b0; // RULE5
      if (!slow_reg || div_reg == `ECDM_SLOW_DIV - `ECDM_ONE8) begin
        div_reg      <= `ECDM_ZERO8;
        instr_clk_en <= 1'b1; // RULE6
      end else begin
        div_reg      <= div_reg + `ECDM_ONE8;
        instr_clk_en <= 1'b0;
      end
    end
  end

  // Hold processor until serial boot is complete and a code image is present or host download is done
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      run_enable <= 1'b0;
    else if (serial_boot_done && (nv_image_present || host_load_done))
      run_enable <= 1'b1; // RULE15 RULE16
  end

  // Space decode and overlay remap
  always @* begin
    is_data   = acc_data_space;
    phys_addr = acc_addr;
    if (!acc_data_space && overlay_sect_en[sect] && !acc_rom_hit) begin
      is_data   = 1'b1; // RULE3
      phys_addr = overlay_addr(acc_addr, usb_mode);
    end
    lim_addr = usb_mode ? (phys_addr & ({ADDR_W{1'b0}} | {`ECDM_USB_ADDR_W{1'b1}})) : phys_addr; // RULE2
    w16 = is_data ? data_width16 : code_width16; // RULE11
    x16 = is_data ? data_type_x16 : code_type_x16;
  end

  // Access sequencer: address, strobe, data return
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= ST_IDLE;
      code_cs_n         <= 1'b1;
      data_cs_n         <= 1'b1;
      mem_addr          <= {(ADDR_W-1){1'b0}};
      byte_pin_multi    <= 1'b1;
      low_write_strobe  <= 1'b1;
      mem_output_enable <= 1'b1;
      lower_byte_enable <= 1'b1;
      mem_dout          <= 16'h0000;
      mem_dout_en       <= 1'b0;
      acc_rdata         <= 16'h0000;
      sel_data_reg      <= 1'b0;
      w16_reg           <= 1'b0;
      x16_reg           <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (acc_req && run_enable && instr_clk_en) begin
            sel_data_reg <= is_data;
            w16_reg      <= w16;
            x16_reg      <= x16;
            code_cs_n    <= is_data;  // RULE1 RULE18
            data_cs_n    <= ~is_data; // RULE1 RULE18
            // In 8-bit spaces the byte pin carries bit 0, so the pins always see bits above it
            mem_addr     <= lim_addr[ADDR_W-1:1]; // RULE8 RULE11
            mem_dout     <= (w16 && acc_byte && lim_addr[0]) ? {acc_wdata[7:0], acc_wdata[7:0]} : acc_wdata;
            mem_dout_en  <= acc_write;
            if (!w16) begin
              byte_pin_multi    <= lim_addr[0]; // RULE8
              lower_byte_enable <= 1'b1;
            end else if (!x16) begin
              byte_pin_multi    <= 1'b1; // RULE9
              lower_byte_enable <= 1'b1;
            end else begin
              byte_pin_multi    <= acc_byte && !lim_addr[0]; // RULE10
              lower_byte_enable <= acc_byte && lim_addr[0];  // RULE10
            end
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (mem_dout_en) begin
            if (w16_reg && !x16_reg) begin
              byte_pin_multi   <= acc_byte && !acc_addr[0]; // RULE9
              low_write_strobe <= acc_byte && acc_addr[0];  // RULE9
            end else begin
              low_write_strobe <= 1'b0; // RULE8 RULE10
            end
          end else begin
            mem_output_enable <= 1'b0; // RULE8 RULE9 RULE10
          end
          state_reg <= ST_STRB;
        end
        ST_STRB: begin
          acc_rdata         <= (!w16_reg) ? {8'h00, mem_din[7:0]} : mem_din;
          low_write_strobe  <= 1'b1;
          mem_output_enable <= 1'b1;
          if (w16_reg && !x16_reg)
            byte_pin_multi <= 1'b1;
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          code_cs_n         <= 1'b1;
          data_cs_n         <= 1'b1;
          byte_pin_multi    <= 1'b1;
          lower_byte_enable <= 1'b1;
          mem_dout_en       <= 1'b0;
          state_reg         <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ecdm_serial_boot #(
    .SYS_HZ (SYS_HZ),
    .SER_HZ (SER_HZ)
  ) u_serial_boot (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (serial_boot_en && !serial_boot_done),
    .ser_clk  (ser_clk),
    .ser_tick (ser_tick)
  );

endmodule
`default_nettype wire

// file: rtl/ecdm_defs.vh
// Shared constants for the external code and data memory controller
`ifndef ECDM_DEFS_VH
`define ECDM_DEFS_VH

`define ECDM_ADDR_W          22
`define ECDM_USB_ADDR_W      20
`define ECDM_CODE_ADDR_W     17
`define ECDM_SECT_W          3
`define ECDM_SECT_LSB        14
`define ECDM_SECT_MSB        16
`define ECDM_SECTIONS        8
`define ECDM_SYS_HZ          200000000
`define ECDM_SER_HZ          400000
`define ECDM_SLOW_DIV        8'h04
`define ECDM_ONE8            8'h01
`define ECDM_ZERO8           8'h00
`define ECDM_WIDTH8          1'b0
`define ECDM_WIDTH16         1'b1
`define ECDM_TYPE_X8         1'b0
`define ECDM_TYPE_X16        1'b1

`endif

// file: rtl/ecdm_serial_boot.v
// Serial boot memory clock generator and boot sequencing pulse
`timescale 1ns/1ps
`default_nettype none
`include "ecdm_defs.vh"

module ecdm_serial_boot #(
  parameter integer SYS_HZ = `ECDM_SYS_HZ,
  parameter integer SER_HZ = `ECDM_SER_HZ
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Control
  input  wire enable,
  // Serial port clock
  output reg  ser_clk,
  output wire ser_tick
);

  localparam integer HALF_CYC = SYS_HZ / (2 * SER_HZ);
  localparam integer CNT_W    = 16;

  reg [CNT_W-1:0] cnt_reg;

  assign ser_tick = enable && (cnt_reg == HALF_CYC[CNT_W-1:0] - 16'h0001) && ser_clk;

  // Divider gives 400 kHz; phase held low while idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      ser_clk <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 16'h0000;
      ser_clk <= 1'b0;
    end else if (cnt_reg == HALF_CYC[CNT_W-1:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      ser_clk <= ~ser_clk; // RULE17
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

endmodule
`default_nettype wire
